// *** eeprom_model.sv ***
// Behavioural two-wire EEPROM that answers random reads at bus address EE_DEV.
// Assumes pull-ups on both lines; the bench resolves the wired-AND levels.
`timescale 1ns/1ps
module eeprom_model
  import sensor_cal_pkg::*;
(
  input wire logic scl,
  input wire logic sda,
  input wire logic present,
  input wire logic slow,
  output logic sda_pull,
  output logic scl_pull
);
  logic [7:0] mem [0:127];
  logic [7:0] sr, ptr;
  logic ack = 0;
  logic nxt;
  int bitc = 0;
  int st = 0;
  initial
  begin
    sda_pull = 0;
    scl_pull = 0;
  end
  always @(negedge sda)
    if (scl === 1'b1)
    begin
      st = 1;
      bitc = 0;
    end
  always @(posedge sda)
    if (scl === 1'b1)
      st = 0;
  always @(posedge scl)
    if (st != 0)
    begin
      if (bitc == 8)
      begin
        bitc = 0;
        if (ack)
          ack = 0;
        else if (sda)
          st = 0;
        else
          ptr = ptr + 1;
      end
      else
      begin
        sr = {sr[6:0], sda};
        bitc = bitc + 1;
        if (bitc == 8 && st != 3)
        begin
          ack = present && (st == 2 || sr[7:1] == EE_DEV);
          if (st == 2)
            ptr = sr;
          st = !ack ? 0 : (st == 2) ? 2 : (sr[0] ? 3 : 2);
        end
      end
    end
  // One assignment per edge so the resolved line never glitches into a false start
  always @(negedge scl)
  begin
    nxt = 0;
    if (st != 0 && bitc == 8 && ack)
      nxt = 1;
    else if (st == 3 && bitc < 8)
      nxt = !mem[ptr[6:0]][7 - bitc];
    sda_pull = nxt;
    if (slow)
    begin
      scl_pull = 1;
      #2000;
      scl_pull = 0;
    end
  end
endmodule

// *** sensor_cal_pkg.sv ***
// Constants shared by the calibration table loader and its two-wire byte engine.
// Assumes a 50 MHz system clock and a two-wire EEPROM with 8-bit word addressing.
package sensor_cal_pkg;
  localparam int CLK_HZ = 50_000_000;
  localparam int TWI_HZ = 65_000;
  localparam int TWI_QTR_CYC = (CLK_HZ + TWI_HZ * 4 - 1) / (TWI_HZ * 4);
  localparam int PWR_WAIT_MS = 25;
  localparam int PWR_WAIT_CYC = CLK_HZ / 1000 * PWR_WAIT_MS;
  localparam int RETRY_S = 1;
  localparam int RETRY_CYC = CLK_HZ * RETRY_S;
  // Bus address of the EEPROM; plain default
  localparam logic [6:0] EE_DEV = 7'h50;
  // Validity flag at locations 0 and 1; value is arbitrary
  localparam logic [15:0] EE_FLAG = 16'ha55a;
  localparam logic [7:0] CFG_ADDR = 8'h00;
  localparam logic [6:0] CFG_BYTES = 7'h0c;
  localparam logic [7:0] TBL_ADDR = 8'h0c;
  localparam logic [6:0] TBL_BYTES = 7'h68;
  localparam logic [4:0] TBL_LAST = 5'h10;
  localparam logic [5:0] TBL_CS_WORD = 6'h33;
  localparam logic [5:0] CFG_CS_WORD = 6'h05;
  localparam logic [7:0] A_STATUS = 8'h00;
  localparam logic [7:0] A_ALARM = 8'h04;
  localparam logic [7:0] A_GAIN = 8'h08;
  localparam logic [7:0] A_ZERO = 8'h0c;
  localparam logic [7:0] A_TEMP = 8'h10;
  localparam logic [7:0] A_LIMIT = 8'h14;
  localparam logic [7:0] A_ISTAT = 8'h18;
  localparam logic [7:0] A_IMASK = 8'h1c;
  localparam logic [7:0] A_CFG_A = 8'h20;
  localparam logic [7:0] A_CFG_B = 8'h24;
  localparam int FE_POL_BIT = 15;
  localparam int FE_LIM_BIT = 14;
  localparam int LIN_SIGN_BIT = 7;
  localparam logic [31:0] LIMIT_RST = 32'h0000_0000;
  localparam logic [3:0] IMASK_RST = 4'h0;
  localparam int EV_APPLY = 0;
  localparam int EV_CSUM = 1;
  localparam int EV_NORESP = 2;
  localparam int EV_FAULT = 3;
  typedef enum logic [1:0] {OP_START = 2'h0, OP_STOP = 2'h1, OP_WRITE = 2'h2, OP_READ = 2'h3}
    twi_op_t;
endpackage

// *** sensor_cal_table_loader.sv ***
// Calibration loader: reads configuration and temperature table from a two-wire
// EEPROM, interpolates DAC codes, monitors faults. APB slave for software.
// Assumes temp_start/temp_done/temp_result come from logic on the same clock.
`timescale 1ns/1ps
module sensor_cal_table_loader
  import sensor_cal_pkg::*;
#(
  parameter int PWR_CYC = PWR_WAIT_CYC,
  parameter int RETRY_WAIT_CYC = RETRY_CYC,
  parameter int TWI_QTR = TWI_QTR_CYC
)
(
  input wire logic clock,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq,
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  output logic temp_start,
  input wire logic temp_done,
  input wire logic [15:0] temp_result,
  input wire logic [3:0] sensor_fault_cmp,
  input wire logic [4:0] fe_fault_cmp,
  output logic [15:0] gain_dac_code,
  output logic [15:0] zero_dac_code,
  output logic out_amp_enable,
  output logic out_hiz,
  output logic out_rail_high,
  output logic out_rail_low,
  output logic limit_enable,
  output logic [15:0] over_limit_code,
  output logic [15:0] under_limit_code,
  output logic lin_dac_sign,
  output logic [6:0] lin_dac_mag,
  output logic lin_enable,
  output logic [15:0] ref_lin_cfg,
  output logic [15:0] coarse_gain_cfg,
  output logic [15:0] frontend_cfg,
  output logic [15:0] temp_adc_cfg
);
  typedef enum logic [5:0] {S_WAIT = 6'b000001, S_XCFG = 6'b000010, S_CONV = 6'b000100,
    S_XTBL = 6'b001000, S_DIV = 6'b010000, S_RETRY = 6'b100000} main_st_t;
  typedef struct packed {
    main_st_t st;
    logic [31:0] cnt;
    logic [2:0] step;
    logic busy;
    logic err;
    logic csok;
    logic [6:0] bcnt;
    logic [7:0] hi;
    logic [15:0] sum;
    logic [15:0] flag;
    logic [3:0][15:0] stg;
    logic [3:0][15:0] cfg;
    logic [15:0] temp;
    logic [1:0] fld;
    logic [4:0] ent;
    logic chosen;
    logic [15:0] ct, cz, pt, pz, pg, lt, lz, lg, ht, hz, hg;
    logic [16:0] rem;
    logic [15:0] den;
    logic [15:0] frac;
    logic [15:0] gain;
    logic [15:0] zero;
    logic amp_en;
    logic hiz;
    logic [1:0][3:0] sens_sy;
    logic [1:0][4:0] fe_sy;
    logic fault;
    logic rail_hi;
    logic rail_lo;
    logic [31:0] limit;
    logic [3:0] istat;
    logic [3:0] imask;
    logic [31:0] rdata;
    logic slverr;
  } main_t;
  main_t s_q, s_d;
  logic [3:0] ev;
  logic [15:0] word;
  logic [5:0] widx;
  logic [6:0] nlast;
  logic [16:0] rem2;
  logic bitq;
  logic signed [16:0] dz, dg;
  logic signed [33:0] pzm, pgm;
  logic cmd_valid, cmd_nack, eng_done, rx_nack;
  twi_op_t cmd_op;
  logic [7:0] cmd_data, rx_data;

  twi_byte_engine #(.QTR_CYC(TWI_QTR)) u_twi (
    .clock(clock),
    .rst(rst),
    .cmd_valid(cmd_valid),
    .cmd_op(cmd_op),
    .cmd_data(cmd_data),
    .cmd_nack(cmd_nack),
    .done(eng_done),
    .rx_data(rx_data),
    .rx_nack(rx_nack),
    .scl_in(scl_in),
    .scl_out(scl_out),
    .scl_oe(scl_oe),
    .sda_in(sda_in),
    .sda_out(sda_out),
    .sda_oe(sda_oe)
  );

  always_comb
  begin
    s_d = s_q;
    ev = 4'h0;
    word = {s_q.hi, rx_data};
    widx = s_q.bcnt[6:1];
    nlast = (s_q.st == S_XTBL) ? 7'(TBL_BYTES - 7'h01) : 7'(CFG_BYTES - 7'h01);
    rem2 = {s_q.rem[15:0], 1'b0};
    bitq = (s_q.den != 16'h0000) && (rem2 >= {1'b0, s_q.den});
    dz = 17'({1'b0, s_q.hz}) - 17'({1'b0, s_q.lz});
    dg = 17'({1'b0, s_q.hg}) - 17'({1'b0, s_q.lg});
    pzm = dz * $signed({1'b0, s_q.frac});
    pgm = dg * $signed({1'b0, s_q.frac});
    cmd_valid = ((s_q.st == S_XCFG) || (s_q.st == S_XTBL)) && !s_q.busy;
    cmd_nack = s_q.bcnt == nlast;
    cmd_data = 8'h00;
    case (s_q.step)
      3'h0, 3'h3: cmd_op = OP_START;
      3'h1:
      begin
        cmd_op = OP_WRITE;
        cmd_data = {EE_DEV, 1'b0};
      end
      3'h2:
      begin
        cmd_op = OP_WRITE;
        cmd_data = (s_q.st == S_XTBL) ? TBL_ADDR : CFG_ADDR;
      end
      3'h4:
      begin
        cmd_op = OP_WRITE;
        cmd_data = {EE_DEV, 1'b1};
      end
      3'h5: cmd_op = OP_READ;
      default: cmd_op = OP_STOP;
    endcase
    temp_start = (s_q.st == S_CONV) && !s_q.busy;
    s_d.sens_sy = {s_q.sens_sy[0], sensor_fault_cmp};
    s_d.fe_sy = {s_q.fe_sy[0], fe_fault_cmp};
    s_d.fault = (|s_q.sens_sy[1]) | (|(s_q.fe_sy[1] & s_q.cfg[2][4:0]));
    // Rails apply even with clipping off
    s_d.rail_hi = s_q.fault & s_q.cfg[2][FE_POL_BIT];
    s_d.rail_lo = s_q.fault & ~s_q.cfg[2][FE_POL_BIT];
    ev[EV_FAULT] = s_d.fault & ~s_q.fault;
    s_d.cnt = s_q.cnt + 32'h1;
    if (cmd_valid || temp_start)
      s_d.busy = 1'b1;
    case (s_q.st)
      S_WAIT:
        if (s_q.cnt >= 32'(PWR_CYC - 1))
          s_d.st = S_XCFG;
      S_RETRY:
        if (s_q.cnt >= 32'(RETRY_WAIT_CYC - 1))
          s_d.st = S_XCFG;
      S_XCFG, S_XTBL:
      begin
        if (eng_done)
        begin
          s_d.busy = 1'b0;
          s_d.step = s_q.step + 3'h1;
          case (s_q.step)
            3'h1, 3'h2, 3'h4:
              if (rx_nack)
              begin
                s_d.err = 1'b1;
                s_d.step = 3'h6;
              end
            3'h5:
            begin
              s_d.step = (s_q.bcnt == nlast) ? 3'h6 : 3'h5;
              s_d.bcnt = s_q.bcnt + 7'h01;
              if (!s_q.bcnt[0])
                s_d.hi = rx_data;
              else if (s_q.st == S_XCFG)
              begin
                if (widx == 6'h00)
                  s_d.flag = word;
                else if (widx == CFG_CS_WORD)
                  s_d.csok = s_q.sum == word;
                else
                begin
                  s_d.stg[2'(widx - 6'h01)] = word;
                  s_d.sum = s_q.sum + word;
                end
              end
              else if (widx == TBL_CS_WORD)
                s_d.csok = s_q.sum == word;
              else
              begin
                s_d.sum = s_q.sum + word;
                s_d.fld = (s_q.fld == 2'h2) ? 2'h0 : s_q.fld + 2'h1;
                if (s_q.fld == 2'h0)
                  s_d.ct = word;
                else if (s_q.fld == 2'h1)
                  s_d.cz = word;
                else
                begin
                  s_d.ent = s_q.ent + 5'h01;
                  // First point at or above temperature closes the segment
                  if (s_q.ent != 5'h00 && !s_q.chosen &&
                      (s_q.temp <= s_q.ct || s_q.ent == TBL_LAST))
                  begin
                    {s_d.lt, s_d.lz, s_d.lg} = {s_q.pt, s_q.pz, s_q.pg};
                    {s_d.ht, s_d.hz, s_d.hg} = {s_q.ct, s_q.cz, word};
                    s_d.chosen = 1'b1;
                  end
                  {s_d.pt, s_d.pz, s_d.pg} = {s_q.ct, s_q.cz, word};
                end
              end
            end
            3'h6:
            begin
              s_d.st = S_RETRY;
              if (s_q.err || (s_q.st == S_XCFG && s_q.flag != EE_FLAG))
                ev[EV_NORESP] = 1'b1;
              else if (!s_q.csok)
              begin
                s_d.hiz = 1'b1;
                s_d.amp_en = 1'b0;
                ev[EV_CSUM] = 1'b1;
              end
              else if (s_q.st == S_XCFG)
              begin
                s_d.cfg = s_q.stg;
                s_d.st = S_CONV;
              end
              else
              begin
                s_d.st = S_DIV;
                s_d.den = s_q.ht - s_q.lt;
                // Outside the stored range the end segment is held at its edge
                if (s_q.temp <= s_q.lt)
                  s_d.rem = 17'h00000;
                else if (s_q.temp >= s_q.ht)
                  s_d.rem = {1'b0, s_q.ht - s_q.lt};
                else
                  s_d.rem = {1'b0, s_q.temp - s_q.lt};
              end
            end
            default: ;
          endcase
        end
      end
      S_CONV:
        if (s_q.busy && temp_done)
        begin
          s_d.temp = temp_result;
          s_d.st = S_XTBL;
        end
      S_DIV:
      begin
        if (s_q.cnt != 32'h10)
        begin
          s_d.rem = bitq ? rem2 - {1'b0, s_q.den} : rem2;
          s_d.frac = {s_q.frac[14:0], bitq};
        end
        else
        begin
          s_d.zero = s_q.lz + pzm[31:16];
          s_d.gain = s_q.lg + pgm[31:16];
          s_d.amp_en = 1'b1;
          s_d.hiz = 1'b0;
          ev[EV_APPLY] = 1'b1;
          s_d.st = S_XCFG;
        end
      end
      default: s_d.st = S_WAIT;
    endcase
    if (s_d.st != s_q.st)
    begin
      s_d.cnt = 32'h0;
      s_d.step = 3'h0;
      s_d.busy = 1'b0;
      s_d.err = 1'b0;
      s_d.csok = 1'b0;
      s_d.bcnt = 7'h00;
      s_d.sum = 16'h0000;
      s_d.fld = 2'h0;
      s_d.ent = 5'h00;
      if (s_d.st == S_XTBL)
        s_d.chosen = 1'b0;
    end
    if (psel && !penable)
    begin
      s_d.slverr = 1'b0;
      case (paddr)
        A_STATUS: s_d.rdata = {22'h0, s_q.st, s_q.csok, s_q.hiz, s_q.amp_en, s_q.fault};
        A_ALARM: s_d.rdata = {23'h0, s_q.fe_sy[1], s_q.sens_sy[1]};
        A_GAIN: s_d.rdata = {16'h0, s_q.gain};
        A_ZERO: s_d.rdata = {16'h0, s_q.zero};
        A_TEMP: s_d.rdata = {16'h0, s_q.temp};
        A_LIMIT: s_d.rdata = s_q.limit;
        A_ISTAT: s_d.rdata = {28'h0, s_q.istat};
        A_IMASK: s_d.rdata = {28'h0, s_q.imask};
        A_CFG_A: s_d.rdata = {s_q.cfg[1], s_q.cfg[0]};
        A_CFG_B: s_d.rdata = {s_q.cfg[3], s_q.cfg[2]};
        default:
        begin
          s_d.rdata = 32'h0;
          s_d.slverr = 1'b1;
        end
      endcase
    end
    if (psel && penable && pwrite)
    begin
      if (paddr == A_LIMIT)
        s_d.limit = pwdata;
      if (paddr == A_IMASK)
        s_d.imask = pwdata[3:0];
      if (paddr == A_ISTAT)
        s_d.istat = s_q.istat & ~pwdata[3:0];
    end
    // A new event wins over a clear in the same cycle
    s_d.istat = s_d.istat | ev;
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      s_q <= '{st: S_WAIT, limit: LIMIT_RST, imask: IMASK_RST, default: '0};
    else
      s_q <= s_d;
  end

  assign prdata = s_q.rdata;
  assign pready = 1'b1;
  assign pslverr = psel && penable && s_q.slverr;
  assign irq = |(s_q.istat & s_q.imask);
  assign gain_dac_code = s_q.gain;
  assign zero_dac_code = s_q.zero;
  assign out_amp_enable = s_q.amp_en;
  assign out_hiz = s_q.hiz;
  assign out_rail_high = s_q.rail_hi;
  assign out_rail_low = s_q.rail_lo;
  assign limit_enable = s_q.cfg[2][FE_LIM_BIT];
  assign over_limit_code = s_q.limit[31:16];
  assign under_limit_code = s_q.limit[15:0];
  assign lin_dac_sign = s_q.cfg[0][LIN_SIGN_BIT];
  assign lin_dac_mag = s_q.cfg[0][6:0];
  assign lin_enable = |s_q.cfg[0][6:0];
  assign ref_lin_cfg = s_q.cfg[0];
  assign coarse_gain_cfg = s_q.cfg[1];
  assign frontend_cfg = s_q.cfg[2];
  assign temp_adc_cfg = s_q.cfg[3];

  a_fault_flag: assert property (@(posedge clock) disable iff (rst)
    (s_q.sens_sy[1] != 4'h0) |=> s_q.fault)
    else $error("comparator trip did not raise fault");
  a_rail_on_fault: assert property (@(posedge clock) disable iff (rst)
    s_q.fault |=> (out_rail_high ^ out_rail_low))
    else $error("fault without exactly one rail");
  a_rail_polarity: assert property (@(posedge clock) disable iff (rst)
    out_rail_high |-> $past(s_q.cfg[2][FE_POL_BIT]))
    else $error("high rail against alarm polarity");
  a_hiz_amp_off: assert property (@(posedge clock) disable iff (rst)
    out_hiz |-> !out_amp_enable)
    else $error("amplifier on while output high impedance");
  a_gain_source: assert property (@(posedge clock) disable iff (rst)
    $changed(gain_dac_code) |-> $past(s_q.st) == S_DIV)
    else $error("gain code changed outside table apply");
  a_zero_source: assert property (@(posedge clock) disable iff (rst)
    $changed(zero_dac_code) |-> $past(s_q.st) == S_DIV)
    else $error("zero code changed outside table apply");
  a_loop_restart: assert property (@(posedge clock) disable iff (rst)
    (s_q.st == S_DIV && s_q.cnt == 32'h10) |=> (s_q.st == S_XCFG && out_amp_enable))
    else $error("apply did not enable output and restart");
  a_interp_span: assert property (@(posedge clock) disable iff (rst)
    (s_q.st == S_DIV && s_q.cnt == 32'h10) |=>
      ((zero_dac_code >= s_q.lz && zero_dac_code <= s_q.hz) ||
       (zero_dac_code <= s_q.lz && zero_dac_code >= s_q.hz)))
    else $error("zero code outside segment end points");
  a_conv_to_table: assert property (@(posedge clock) disable iff (rst)
    (s_q.st == S_CONV && s_q.busy && temp_done) |=>
      (s_q.st == S_XTBL && s_q.temp == $past(temp_result)))
    else $error("conversion result not taken for table read");
  a_cfg_commit: assert property (@(posedge clock) disable iff (rst)
    $changed(frontend_cfg) |-> $past(s_q.st) == S_XCFG)
    else $error("configuration changed outside config load");
  a_retry_hold: assert property (@(posedge clock) disable iff (rst)
    ($past(s_q.st) != S_RETRY && s_q.st == S_RETRY) |-> (s_q.st == S_RETRY) [*8])
    else $error("retry wait cut short");
endmodule

// *** sensor_cal_table_loader_test.sv ***
// Self-checking bench: APB registers, faults, retry, table load and checksum failure.
// Assumes eeprom_model on the two-wire pins and a bench-side temperature converter.
`timescale 1ns/1ps
module sensor_cal_table_loader_test;
  import sensor_cal_pkg::*;
  logic clock = 0;
  logic rst = 1;
  logic psel = 0, penable = 0, pwrite = 0, temp_done = 0, present = 0, slow = 0;
  logic [7:0] paddr = 0;
  logic [31:0] pwdata = 0;
  logic [15:0] temp_result = 0;
  logic [3:0] sensor_fault_cmp = 0;
  logic [4:0] fe_fault_cmp = 0;
  logic [31:0] prdata, rd, lim;
  logic pready, pslverr, irq, scl_oe, sda_oe, temp_start, ee_sda, ee_scl, er, scl, sda;
  logic [15:0] gain_dac_code, zero_dac_code, over_limit_code, under_limit_code;
  logic [15:0] ref_lin_cfg, coarse_gain_cfg, frontend_cfg, temp_adc_cfg;
  logic out_amp_enable, out_hiz, out_rail_high, out_rail_low, limit_enable;
  logic lin_dac_sign, lin_enable;
  logic [6:0] lin_dac_mag;
  logic [15:0] img [0:57];
  int compares = 0, miscompares = 0, tcnt = 0;
  assign scl = ~(scl_oe | ee_scl);
  assign sda = ~(sda_oe | ee_sda);
  always #10 clock = ~clock;
  // Short link quarter keeps the full table load within the cycle budget
  sensor_cal_table_loader #(.PWR_CYC(50), .RETRY_WAIT_CYC(40), .TWI_QTR(8)) u_dut (
    .clock, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .irq, .scl_in(scl), .scl_out(), .scl_oe, .sda_in(sda), .sda_out(),
    .sda_oe, .temp_start, .temp_done, .temp_result, .sensor_fault_cmp, .fe_fault_cmp,
    .gain_dac_code, .zero_dac_code, .out_amp_enable, .out_hiz, .out_rail_high,
    .out_rail_low, .limit_enable, .over_limit_code, .under_limit_code, .lin_dac_sign,
    .lin_dac_mag, .lin_enable, .ref_lin_cfg, .coarse_gain_cfg, .frontend_cfg,
    .temp_adc_cfg);
  eeprom_model u_ee (.scl, .sda, .present, .slow, .sda_pull(ee_sda), .scl_pull(ee_scl));
  // Converter model: finishes 20 cycles after each start request
  always @(posedge clock)
  begin
    temp_done <= (tcnt == 1);
    if (temp_start)
      tcnt <= 20;
    else if (tcnt != 0)
      tcnt <= tcnt - 1;
  end
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[FAIL] %s exp %h got %h", nm, exp, got);
    end
  endtask
  task automatic wrap_up;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1;
    do
    begin
      @(posedge clock);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    rd = prdata;
    er = pslverr;
    chk("pready", pready, 1);
    psel <= 0;
    penable <= 0;
    @(posedge clock);
  endtask
  task automatic wait_irq(input int lim_cyc);
    int n;
    n = 0;
    // Poll between edges so registered outputs have settled
    @(negedge clock);
    while (irq !== 1'b1 && n < lim_cyc)
    begin
      @(negedge clock);
      n++;
    end
    // Rails follow the flag one cycle later
    @(negedge clock);
    chk("irq", irq, 1);
    @(posedge clock);
  endtask
  task automatic fault(input logic pol);
    logic [3:0] s;
    logic [4:0] f;
    s = 4'($urandom_range(15, 1));
    f = 5'($urandom);
    apb(1, A_IMASK, 32'h8);
    sensor_fault_cmp <= s;
    fe_fault_cmp <= f;
    wait_irq(20);
    chk("rail_high", out_rail_high, pol);
    chk("rail_low", out_rail_low, !pol);
    apb(0, A_ALARM, 0);
    chk("alarm", rd, {f, s});
    sensor_fault_cmp <= 0;
    fe_fault_cmp <= 0;
    apb(1, A_ISTAT, 32'h8);
    repeat (3) @(posedge clock);
    chk("irq_clr", irq, 0);
    chk("rail_off", out_rail_low | out_rail_high, 0);
  endtask
  // Expected code: bracketing segment, clamped at the ends, floor interpolation
  function automatic logic [15:0] interp(input logic [15:0] t, input int k);
    int s;
    longint tl, th, tc, f, cl, ch;
    s = 16;
    for (int i = 16; i >= 1; i--)
      if (t <= img[6 + 3 * i])
        s = i;
    tl = img[3 + 3 * s];
    th = img[6 + 3 * s];
    tc = t < tl ? tl : t > th ? th : t;
    f = (tc - tl) * 65536 / (th - tl);
    cl = img[3 + 3 * s + k];
    ch = img[6 + 3 * s + k];
    return 16'(cl + (((ch - cl) * (f > 65535 ? 65535 : f)) >>> 16));
  endfunction
  initial
  begin
    void'($urandom(32'hff6886c2));
    for (int i = 0; i < 51; i++)
      img[6 + i] = (i % 3 == 0) ? 16'(16'h0800 + (i / 3) * 16'h0c00) : 16'($urandom);
    img[0] = EE_FLAG;
    img[1] = 16'($urandom) & 16'hff80;
    for (int i = 2; i < 5; i++)
      img[i] = 16'($urandom);
    img[5] = img[1] + img[2] + img[3] + img[4];
    img[57] = 0;
    for (int i = 6; i < 57; i++)
      img[57] = img[57] + img[i];
    for (int i = 0; i < 58; i++)
      {u_ee.mem[2 * i], u_ee.mem[2 * i + 1]} = img[i];
    temp_result = 16'($urandom);
    repeat (8) @(posedge clock);
    rst <= 0;
    @(posedge clock);
    apb(0, A_LIMIT, 0);
    chk("limit_rst", rd, LIMIT_RST);
    apb(0, A_IMASK, 0);
    chk("imask_rst", rd, 32'(IMASK_RST));
    apb(0, 8'h28, 0);
    chk("unmapped", er, 1);
    lim = $urandom;
    apb(1, A_LIMIT, lim);
    chk("over", over_limit_code, lim[31:16]);
    chk("under", under_limit_code, lim[15:0]);
    apb(1, A_GAIN, lim);
    apb(0, A_GAIN, 0);
    chk("gain_ro", rd, 0);
    fault(0);
    apb(1, A_IMASK, 32'h4);
    wait_irq(20000);
    chk("amp_off", out_amp_enable, 0);
    present <= 1;
    apb(1, A_ISTAT, 32'h4);
    apb(1, A_IMASK, 32'h1);
    wait_irq(60000);
    chk("amp_on", out_amp_enable, 1);
    chk("hiz_off", out_hiz, 0);
    chk("gain", gain_dac_code, interp(temp_result, 2));
    chk("zero", zero_dac_code, interp(temp_result, 1));
    apb(0, A_ZERO, 0);
    chk("zero_reg", rd, 32'(interp(temp_result, 1)));
    apb(0, A_TEMP, 0);
    chk("temp", rd, 32'(temp_result));
    chk("cfg_a", {coarse_gain_cfg, ref_lin_cfg}, {img[2], img[1]});
    chk("cfg_b", {temp_adc_cfg, frontend_cfg}, {img[4], img[3]});
    chk("lin", {lin_enable, lin_dac_sign, lin_dac_mag}, {1'b0, img[1][7], 7'h0});
    chk("lim_en", limit_enable, img[3][14]);
    fault(img[3][15]);
    u_ee.mem[11] = ~u_ee.mem[11];
    slow <= 1;
    apb(1, A_IMASK, 32'h2);
    wait_irq(30000);
    chk("hiz_on", out_hiz, 1);
    chk("amp_dis", out_amp_enable, 0);
    wrap_up;
  end
  initial
  begin
    #2_000_000;
    miscompares++;
    wrap_up;
  end
endmodule

// *** twi_byte_engine.sv ***
// Two-wire master bit engine: start, stop, byte write with ack, byte read.
// Assumes open-drain pins with pull-ups outside; honours clock stretching.
`timescale 1ns/1ps
module twi_byte_engine
  import sensor_cal_pkg::*;
#(
  // Quarter of a bit period in clocks; a bench may shorten it to keep runs brief
  parameter int QTR_CYC = TWI_QTR_CYC
)
(
  input wire logic clock,
  input wire logic rst,
  input wire logic cmd_valid,
  input wire twi_op_t cmd_op,
  input wire logic [7:0] cmd_data,
  input wire logic cmd_nack,
  output logic done,
  output logic [7:0] rx_data,
  output logic rx_nack,
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe
);
  typedef enum logic [1:0] {E_IDLE = 2'b01, E_RUN = 2'b10} eng_st_t;
  typedef struct packed {
    eng_st_t st;
    twi_op_t op;
    logic [7:0] tx;
    logic last_nack;
    logic [3:0] bitn;
    logic [1:0] ph;
    logic [7:0] tick;
    logic scl;
    logic sda;
    logic [7:0] rx;
    logic nack;
    logic done;
    logic [1:0] sda_sy;
    logic [1:0] scl_sy;
  } eng_t;
  localparam logic [7:0] QTR_LAST = 8'(QTR_CYC - 1);
  eng_t s_q, s_d;
  logic is_byte;

  always_comb
  begin
    s_d = s_q;
    s_d.done = 1'b0;
    s_d.sda_sy = {s_q.sda_sy[0], sda_in};
    s_d.scl_sy = {s_q.scl_sy[0], scl_in};
    is_byte = (s_q.op == OP_WRITE) || (s_q.op == OP_READ);
    case (s_q.st)
      E_IDLE:
      begin
        if (cmd_valid)
        begin
          s_d.st = E_RUN;
          s_d.op = cmd_op;
          s_d.tx = cmd_data;
          s_d.last_nack = cmd_nack;
          s_d.bitn = 4'h0;
          s_d.ph = 2'h0;
          s_d.tick = 8'h00;
        end
      end
      E_RUN:
      begin
        if (s_q.tick != QTR_LAST)
          s_d.tick = s_q.tick + 8'h01;
        // A slave holding the clock low stalls the high phase
        else if (s_q.ph != 2'h2 || s_q.scl_sy[1])
        begin
          s_d.tick = 8'h00;
          s_d.ph = s_q.ph + 2'h1;
          case (s_q.ph)
            2'h0:
            begin
              if (s_q.op == OP_START)
                s_d.sda = 1'b1;
              else if (s_q.op == OP_STOP)
                s_d.sda = 1'b0;
              else if (s_q.bitn[3])
                s_d.sda = (s_q.op == OP_READ) ? s_q.last_nack : 1'b1;
              else
                s_d.sda = (s_q.op == OP_WRITE) ? s_q.tx[7] : 1'b1;
            end
            2'h1: s_d.scl = 1'b1;
            2'h2:
            begin
              if (s_q.op == OP_START)
                s_d.sda = 1'b0;
              else if (s_q.op == OP_STOP)
                s_d.sda = 1'b1;
              else if (s_q.bitn[3])
                s_d.nack = s_q.sda_sy[1];
              else
                s_d.rx = {s_q.rx[6:0], s_q.sda_sy[1]};
            end
            default:
            begin
              if (s_q.op != OP_STOP)
                s_d.scl = 1'b0;
              s_d.tx = {s_q.tx[6:0], 1'b0};
              s_d.bitn = s_q.bitn + 4'h1;
              if (!is_byte || s_q.bitn[3])
              begin
                s_d.st = E_IDLE;
                s_d.done = 1'b1;
              end
            end
          endcase
        end
      end
      default: s_d.st = E_IDLE;
    endcase
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      s_q <= '{st: E_IDLE, op: OP_START, scl: 1'b1, sda: 1'b1, default: '0};
    else
      s_q <= s_d;
  end

  assign done = s_q.done;
  assign rx_data = s_q.rx;
  assign rx_nack = s_q.nack;
  assign scl_out = 1'b0;
  assign sda_out = 1'b0;
  assign scl_oe = ~s_q.scl;
  assign sda_oe = ~s_q.sda;

  a_sda_hold: assert property (@(posedge clock) disable iff (rst)
    (s_q.scl && $past(s_q.scl) && $changed(s_q.sda)) |-> !is_byte)
    else $error("data line moved while clock high");
endmodule
